// ==== src/ris_pkg.sv ====
// package for the reset and interrupt sequencer
package ris_pkg;
	// **********************************
	// timing
	// **********************************
	localparam int CLK_PERIOD_PS = 4000;
	localparam int PHASE_DIV = 4;
	localparam int PWR_HOLD_MS = 100;
	localparam int RUN_HOLD_PHASES = 3;

	// **********************************
	// vector addresses
	// **********************************
	localparam logic [15:0] VEC_RESTART = 16'hFFFE;
	localparam logic [15:0] VEC_NONMASK = 16'hFFFC;
	localparam logic [15:0] VEC_TRAP = 16'hFFFA;
	localparam logic [15:0] VEC_EXT = 16'hFFF8;
	localparam logic [15:0] VEC_CAPTURE = 16'hFFF6;
	localparam logic [15:0] VEC_COMPARE = 16'hFFF4;
	localparam logic [15:0] VEC_OVERFLOW = 16'hFFF2;
	localparam logic [15:0] VEC_SERIAL = 16'hFFF0;

	// **********************************
	// register map (byte addresses)
	// **********************************
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_STAT = 4'h4;
	localparam logic [3:0] ADDR_PORT2 = 4'h8;
	localparam logic [3:0] ADDR_VEC = 4'hC;
	localparam int CTRL_CLR_MASK = 0;
	localparam int CTRL_SET_MASK = 1;
	localparam int CTRL_INSTR_DONE = 2;
	localparam int CTRL_TRAP = 3;
	localparam int MODE_LSB = 5;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// **********************************
	// types
	// **********************************
	typedef enum logic [2:0]
	{
		ST_RESET = 3'b000,
		ST_RUN = 3'b001,
		ST_STACK = 3'b011,
		ST_VECTOR = 3'b010
	} ris_state_type;

	typedef struct packed
	{
		logic capture_request;
		logic compare_match_request;
		logic counter_overflow_request;
		logic receive_full_flag;
		logic overrun_framing_flag;
		logic transmit_empty_flag;
	} ris_periph_type;
endpackage : ris_pkg

// ==== src/ris_sequencer.sv ====
// reset and interrupt sequencer with axi4-lite control
`timescale 1ns/10ps
module ris_sequencer
	import ris_pkg::*;
#(
	parameter int STACK_BYTES = 7
)
(
	input wire logic REF_CLK_IN,
	input wire logic SRST_IN,
	input wire logic RESET_INPUT_LOW_IN,
	input wire logic NMI_LOW_IN,
	input wire logic EXTERNAL_MASKABLE_REQUEST_LOW_IN,
	input wire logic [2:0] MODE_PINS_IN,
	input wire ris_periph_type PERIPH_IN,
	output logic PHASE_CLK_OUT,
	output logic [7:0] UPPER_ADDR_OUT,
	output logic [15:0] FETCH_ADDR_OUT,
	output logic FETCH_STB_OUT,
	output logic [2:0] STACK_IDX_OUT,
	output logic STACK_STB_OUT,
	input wire logic [31:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [31:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY
);
	if (STACK_BYTES != 7)
	begin : g_bad_stack
		$error("stack sequence needs exactly seven bytes");
	end

	// **********************************
	// pin synchronisers, three stages
	// **********************************
	logic [2:0] rst_sync_ff;
	logic [2:0] nmi_sync_ff;
	logic [2:0] irq_sync_ff;
	logic [2:0] mode_s1_ff;
	logic [2:0] mode_s2_ff;
	logic [2:0] mode_s3_ff;
	logic rst_low_ff;
	logic nmi_low_ff;
	logic irq_low_ff;

	always_ff @(posedge REF_CLK_IN)
	begin
		if (SRST_IN)
		begin
			rst_sync_ff <= 3'b000;
			nmi_sync_ff <= 3'b111;
			irq_sync_ff <= 3'b111;
			mode_s1_ff <= 3'b000;
			mode_s2_ff <= 3'b000;
			mode_s3_ff <= 3'b000;
		end
		else
		begin
			rst_sync_ff <= {rst_sync_ff[1:0], RESET_INPUT_LOW_IN};
			nmi_sync_ff <= {nmi_sync_ff[1:0], NMI_LOW_IN};
			irq_sync_ff <= {irq_sync_ff[1:0], EXTERNAL_MASKABLE_REQUEST_LOW_IN};
			mode_s1_ff <= MODE_PINS_IN;
			mode_s2_ff <= mode_s1_ff;
			mode_s3_ff <= mode_s2_ff;
		end
	end

	// filtered levels: change once stages two and three agree
	always_ff @(posedge REF_CLK_IN)
	begin
		if (SRST_IN)
		begin
			rst_low_ff <= 1'b1;
			nmi_low_ff <= 1'b1;
			irq_low_ff <= 1'b1;
		end
		else
		begin
			if (rst_sync_ff[1] == rst_sync_ff[2])
				rst_low_ff <= ~rst_sync_ff[2];
			if (nmi_sync_ff[1] == nmi_sync_ff[2])
				nmi_low_ff <= nmi_sync_ff[2];
			if (irq_sync_ff[1] == irq_sync_ff[2])
				irq_low_ff <= irq_sync_ff[2];
		end
	end
	// rst_low_ff holds 1 while reset pin is low (asserted)

	// **********************************
	// bus-phase divider
	// **********************************
	logic [1:0] div_ff;
	logic phase_en;

	always_ff @(posedge REF_CLK_IN)
	begin
		if (SRST_IN)
			div_ff <= 2'b00;
		else
			div_ff <= div_ff + 2'b01;
	end
	assign phase_en = (div_ff == 2'(PHASE_DIV - 1));

	always_ff @(posedge REF_CLK_IN)
	begin
		if (SRST_IN)
			PHASE_CLK_OUT <= 1'b0;
		else
			PHASE_CLK_OUT <= div_ff[1];
	end

	// **********************************
	// phase-rate sampling and nmi edge
	// **********************************
	logic nmi_prev_ff;
	logic nmi_pend_ff;
	logic irq_lvl_ff;
	logic in_reset_ff;
	logic mask_ff;
	logic [2:0] mode_ff;
	logic instr_done_ff;
	logic trap_pend_ff;
	ris_periph_type per_ff;
	ris_state_type state_ff;
	logic [2:0] stack_cnt_ff;
	logic [15:0] vec_ff;
	logic take_nmi;
	logic nmi_edge;
	logic int_req;
	logic [15:0] nxt_vec;
	logic nxt_service;
	logic nxt_set_mask;
	logic aw_got_ff;
	logic w_got_ff;
	logic aw_bad_ff;
	logic [3:0] aw_addr_ff;
	logic wr_ctrl;
	logic [7:0] wdata_ff;

	assign nmi_edge = nmi_prev_ff & ~nmi_low_ff;

	always_ff @(posedge REF_CLK_IN)
	begin
		if (SRST_IN)
		begin
			nmi_prev_ff <= 1'b1;
			irq_lvl_ff <= 1'b0;
			per_ff <= '0;
		end
		else if (phase_en)
		begin
			nmi_prev_ff <= nmi_low_ff;
			irq_lvl_ff <= ~irq_low_ff;
			per_ff <= PERIPH_IN;
		end
	end

	// nmi pending flag: set wins over clear
	always_ff @(posedge REF_CLK_IN)
	begin
		if (SRST_IN || in_reset_ff)
			nmi_pend_ff <= 1'b0;
		else if (phase_en && nmi_edge)
			nmi_pend_ff <= 1'b1;
		else if (take_nmi)
			nmi_pend_ff <= 1'b0;
	end

	// **********************************
	// priority and vector selection
	// **********************************
	assign int_req = |per_ff;

	always_comb
	begin
		nxt_vec = VEC_RESTART;
		nxt_service = 1'b0;
		nxt_set_mask = 1'b0;
		if (nmi_pend_ff)
		begin
			nxt_vec = VEC_NONMASK;
			nxt_service = 1'b1;
		end
		else if (trap_pend_ff)
		begin
			nxt_vec = VEC_TRAP;
			nxt_service = 1'b1;
			nxt_set_mask = 1'b1;
		end
		else if (!mask_ff && irq_lvl_ff)
		begin
			nxt_vec = VEC_EXT;
			nxt_service = 1'b1;
			nxt_set_mask = 1'b1;
		end
		else if (!mask_ff && int_req)
		begin
			nxt_service = 1'b1;
			nxt_set_mask = 1'b1;
			if (per_ff.capture_request)
				nxt_vec = VEC_CAPTURE;
			else if (per_ff.compare_match_request)
				nxt_vec = VEC_COMPARE;
			else if (per_ff.counter_overflow_request)
				nxt_vec = VEC_OVERFLOW;
			else
				nxt_vec = VEC_SERIAL;
		end
	end

	assign take_nmi = phase_en && (state_ff == ST_RUN) && instr_done_ff && nmi_pend_ff;

	// **********************************
	// sequencer
	// **********************************
	always_ff @(posedge REF_CLK_IN)
	begin
		if (SRST_IN || rst_low_ff)
		begin
			state_ff <= ST_RESET;
			stack_cnt_ff <= 3'd0;
			vec_ff <= VEC_RESTART;
			in_reset_ff <= 1'b1;
		end
		else if (phase_en)
		begin
			case (state_ff)
				ST_RESET:
				begin
					in_reset_ff <= 1'b0;
					vec_ff <= VEC_RESTART;
					state_ff <= ST_VECTOR;
				end
				ST_RUN:
				begin
					if (instr_done_ff && nxt_service)
					begin
						vec_ff <= nxt_vec;
						stack_cnt_ff <= 3'd0;
						state_ff <= ST_STACK;
					end
				end
				ST_STACK:
				begin
					if (stack_cnt_ff == 3'(STACK_BYTES - 1))
						state_ff <= ST_VECTOR;
					else
						stack_cnt_ff <= stack_cnt_ff + 3'd1;
				end
				ST_VECTOR:
					state_ff <= ST_RUN;
				default:
					state_ff <= ST_RESET;
			endcase
		end
	end

	// mask bit: hardware set wins over software clear
	always_ff @(posedge REF_CLK_IN)
	begin
		if (SRST_IN || rst_low_ff)
			mask_ff <= 1'b1;
		else if (phase_en && state_ff == ST_RUN && instr_done_ff && nxt_set_mask)
			mask_ff <= 1'b1;
		else if (wr_ctrl && wdata_ff[CTRL_SET_MASK])
			mask_ff <= 1'b1;
		else if (wr_ctrl && wdata_ff[CTRL_CLR_MASK])
			mask_ff <= 1'b0;
	end

	// mode pins captured while reset pin is held
	always_ff @(posedge REF_CLK_IN)
	begin
		if (SRST_IN)
			mode_ff <= 3'b000;
		else if (rst_low_ff && mode_s2_ff == mode_s3_ff)
			mode_ff <= mode_s3_ff;
	end

	// **********************************
	// address outputs
	// **********************************
	always_ff @(posedge REF_CLK_IN)
	begin
		if (SRST_IN)
		begin
			UPPER_ADDR_OUT <= 8'h00;
			FETCH_ADDR_OUT <= 16'h0000;
			FETCH_STB_OUT <= 1'b0;
			STACK_IDX_OUT <= 3'd0;
			STACK_STB_OUT <= 1'b0;
		end
		else
		begin
			FETCH_STB_OUT <= phase_en && state_ff == ST_VECTOR && !rst_low_ff;
			STACK_STB_OUT <= phase_en && state_ff == ST_STACK && !rst_low_ff;
			STACK_IDX_OUT <= stack_cnt_ff;
			FETCH_ADDR_OUT <= vec_ff;
			if (!rst_low_ff && in_reset_ff)
				UPPER_ADDR_OUT <= 8'hFF;
		end
	end

	// **********************************
	// axi4-lite slave
	// **********************************
	always_ff @(posedge REF_CLK_IN)
	begin
		if (SRST_IN)
		begin
			aw_got_ff <= 1'b0;
			w_got_ff <= 1'b0;
			aw_addr_ff <= 4'h0;
			aw_bad_ff <= 1'b0;
			S_AXI_AWREADY <= 1'b0;
			S_AXI_WREADY <= 1'b0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= RESP_OKAY;
		end
		else
		begin
			S_AXI_AWREADY <= !aw_got_ff && !S_AXI_AWREADY && !S_AXI_BVALID;
			S_AXI_WREADY <= !w_got_ff && !S_AXI_WREADY && !S_AXI_BVALID;
			if (S_AXI_AWVALID && S_AXI_AWREADY)
			begin
				aw_got_ff <= 1'b1;
				aw_addr_ff <= S_AXI_AWADDR[3:0];
				aw_bad_ff <= (|S_AXI_AWADDR[31:4]) || (|S_AXI_AWADDR[1:0]);
			end
			if (S_AXI_WVALID && S_AXI_WREADY)
				w_got_ff <= 1'b1;
			if (aw_got_ff && w_got_ff && !S_AXI_BVALID)
			begin
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP <= aw_bad_ff ? RESP_SLVERR : RESP_OKAY;
				aw_got_ff <= 1'b0;
				w_got_ff <= 1'b0;
			end
			else if (S_AXI_BVALID && S_AXI_BREADY)
				S_AXI_BVALID <= 1'b0;
		end
	end

	// control writes: completion flag clears at the next run-state phase, trap stays pending until taken
	assign wr_ctrl = aw_got_ff && w_got_ff && !S_AXI_BVALID && !aw_bad_ff && aw_addr_ff == ADDR_CTRL;

	always_ff @(posedge REF_CLK_IN)
	begin
		if (SRST_IN)
			wdata_ff <= 8'h00;
		else if (S_AXI_WVALID && S_AXI_WREADY)
			wdata_ff <= S_AXI_WSTRB[0] ? S_AXI_WDATA[7:0] : 8'h00;
	end

	always_ff @(posedge REF_CLK_IN)
	begin
		if (SRST_IN || rst_low_ff)
		begin
			instr_done_ff <= 1'b0;
			trap_pend_ff <= 1'b0;
		end
		else
		begin
			if (wr_ctrl && wdata_ff[CTRL_INSTR_DONE])
				instr_done_ff <= 1'b1;
			else if (phase_en && state_ff == ST_RUN)
				instr_done_ff <= 1'b0;
			if (wr_ctrl && wdata_ff[CTRL_TRAP])
				trap_pend_ff <= 1'b1;
			else if (phase_en && state_ff == ST_RUN && instr_done_ff && !nmi_pend_ff)
				trap_pend_ff <= 1'b0;
		end
	end

	always_ff @(posedge REF_CLK_IN)
	begin
		if (SRST_IN)
		begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h0000_0000;
			S_AXI_RRESP <= RESP_OKAY;
		end
		else if (S_AXI_RVALID)
		begin
			if (S_AXI_RREADY)
				S_AXI_RVALID <= 1'b0;
		end
		else if (S_AXI_ARVALID && S_AXI_ARREADY)
		begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID <= 1'b1;
			S_AXI_RRESP <= RESP_OKAY;
			case ({|S_AXI_ARADDR[31:4], S_AXI_ARADDR[3:0]})
				{1'b0, ADDR_CTRL}: S_AXI_RDATA <= {28'h000_0000, trap_pend_ff, instr_done_ff, mask_ff, 1'b0};
				{1'b0, ADDR_STAT}: S_AXI_RDATA <= {24'h00_0000, nmi_pend_ff, irq_lvl_ff, int_req, 2'b00, state_ff};
				{1'b0, ADDR_PORT2}: S_AXI_RDATA <= {24'h00_0000, mode_ff, 5'b0_0000};
				{1'b0, ADDR_VEC}: S_AXI_RDATA <= {16'h0000, vec_ff};
				default:
				begin
					S_AXI_RDATA <= 32'h0000_0000;
					S_AXI_RRESP <= RESP_SLVERR;
				end
			endcase
		end
		else
			S_AXI_ARREADY <= S_AXI_ARVALID;
	end
endmodule : ris_sequencer

// ==== testbench/ris_chk.sv ====
// assertion checker for the reset and interrupt sequencer
`timescale 1ns/10ps
module ris_chk
	import ris_pkg::*;
(
	input wire logic REF_CLK_IN,
	input wire logic SRST_IN,
	input wire logic RESET_INPUT_LOW_IN,
	input wire logic PHASE_CLK_OUT,
	input wire logic [7:0] UPPER_ADDR_OUT,
	input wire logic [15:0] FETCH_ADDR_OUT,
	input wire logic FETCH_STB_OUT,
	input wire logic [2:0] STACK_IDX_OUT,
	input wire logic STACK_STB_OUT
);
	logic seen_low_ff;
	logic [2:0] stk_cnt_ff;
	default clocking @(posedge REF_CLK_IN); endclocking
	default disable iff (SRST_IN);
	always_ff @(posedge REF_CLK_IN)
	begin
		if (SRST_IN)
			seen_low_ff <= 1'b0;
		else if (!RESET_INPUT_LOW_IN)
			seen_low_ff <= 1'b1;
	end
	// expected index of the next stacked byte
	always_ff @(posedge REF_CLK_IN)
	begin
		if (SRST_IN || !RESET_INPUT_LOW_IN || FETCH_STB_OUT)
			stk_cnt_ff <= 3'h0;
		else if (STACK_STB_OUT)
			stk_cnt_ff <= stk_cnt_ff + 3'h1;
	end
	a_phase_period: assert property (@(posedge REF_CLK_IN) disable iff (SRST_IN || !RESET_INPUT_LOW_IN)
		$rose(PHASE_CLK_OUT) |-> ##4 $rose(PHASE_CLK_OUT)) else $error("phase period wrong");
	a_upper_high: assert property ((seen_low_ff && RESET_INPUT_LOW_IN)[*8] |-> UPPER_ADDR_OUT == 8'hFF)
		else $error("upper address not high");
	a_restart_fetch: assert property ($rose(RESET_INPUT_LOW_IN) |->
		##[1:40] FETCH_STB_OUT && FETCH_ADDR_OUT == VEC_RESTART) else $error("no restart fetch");
	a_vector_range: assert property (FETCH_STB_OUT |->
		FETCH_ADDR_OUT[15:4] == 12'hFFF && !FETCH_ADDR_OUT[0]) else $error("vector out of table");
	a_stack_order: assert property (STACK_STB_OUT |-> STACK_IDX_OUT == stk_cnt_ff)
		else $error("stack order wrong");
	a_stack_gap: assert property (STACK_STB_OUT |=> !STACK_STB_OUT [*3])
		else $error("stack faster than phase");
	a_stack_vector: assert property (STACK_STB_OUT && STACK_IDX_OUT == 3'h6 |->
		##[1:8] FETCH_STB_OUT && FETCH_ADDR_OUT != VEC_RESTART) else $error("no vector after stack");
	a_fetch_pulse: assert property (FETCH_STB_OUT |=> !FETCH_STB_OUT)
		else $error("fetch strobe too long");
endmodule : ris_chk
bind ris_sequencer ris_chk u_chk (.REF_CLK_IN, .SRST_IN, .RESET_INPUT_LOW_IN, .PHASE_CLK_OUT,
	.UPPER_ADDR_OUT, .FETCH_ADDR_OUT, .FETCH_STB_OUT, .STACK_IDX_OUT, .STACK_STB_OUT);

// ==== testbench/ris_src.sv ====
// model of the reset source and the request sources
`timescale 1ns/10ps
module ris_src
	import ris_pkg::*;
(
	input wire logic clk_in,
	output logic reset_low_out,
	output logic nmi_low_out,
	output logic ext_req_low_out,
	output logic [2:0] mode_out,
	output ris_periph_type periph_out
);
	initial
	begin
		reset_low_out = 1'b0; // power-up hold until first release, scaled to sim length
		nmi_low_out = 1'b1;
		ext_req_low_out = 1'b1;
		mode_out = 3'h0;
		periph_out = 6'h00;
	end
	task automatic pin_reset(input logic [2:0] m);
		@(posedge clk_in);
		reset_low_out <= 1'b0;
		mode_out <= m;
		repeat (PHASE_DIV * RUN_HOLD_PHASES + 4) @(posedge clk_in);
		reset_low_out <= 1'b1;
		// pins turn to port use after release
		fork
			begin
				repeat (8) @(posedge clk_in);
				mode_out <= ~m;
			end
		join_none
	endtask : pin_reset
	task automatic drive(input logic nmi_low, input logic ext_low, input ris_periph_type p);
		@(posedge clk_in);
		nmi_low_out <= nmi_low;
		ext_req_low_out <= ext_low;
		periph_out <= p;
	endtask : drive
endmodule : ris_src

// ==== testbench/test_reset_interrupt_sequencer.sv ====
// testbench for the reset and interrupt sequencer
`timescale 1ns/10ps
module test_reset_interrupt_sequencer
	import ris_pkg::*;
;
	logic clk, srst, awv, wv, bready, arv, rready, awrdy, wrdy, bvalid, arrdy, rvalid;
	logic [31:0] awaddr, wdata, araddr, rdata;
	logic [1:0] bresp, rresp;
	logic rst_low, nmi_low, ext_low, phase, fetch_stb, stack_stb;
	logic [2:0] mode, stack_idx;
	logic [7:0] upper;
	logic [15:0] fetch_addr, got_vec;
	ris_periph_type periph;
	int error_cnt, num_checks, stk_seen, vec_cnt;
	ris_src src (.clk_in(clk), .reset_low_out(rst_low), .nmi_low_out(nmi_low),
		.ext_req_low_out(ext_low), .mode_out(mode), .periph_out(periph));
	ris_sequencer dut (.REF_CLK_IN(clk), .SRST_IN(srst), .RESET_INPUT_LOW_IN(rst_low),
		.NMI_LOW_IN(nmi_low), .EXTERNAL_MASKABLE_REQUEST_LOW_IN(ext_low), .MODE_PINS_IN(mode),
		.PERIPH_IN(periph), .PHASE_CLK_OUT(phase), .UPPER_ADDR_OUT(upper),
		.FETCH_ADDR_OUT(fetch_addr), .FETCH_STB_OUT(fetch_stb), .STACK_IDX_OUT(stack_idx),
		.STACK_STB_OUT(stack_stb), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv),
		.S_AXI_AWREADY(awrdy), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv),
		.S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arrdy), .S_AXI_RDATA(rdata),
		.S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// strobes are one-cycle pulses, counted at the next edge
	always @(posedge clk)
	begin
		if (stack_stb === 1'b1)
			stk_seen++;
		if (fetch_stb === 1'b1)
		begin
			vec_cnt++;
			got_vec = fetch_addr;
		end
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bready <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			if (awrdy)
				awv <= 1'b0;
			if (wrdy)
				wv <= 1'b0;
			n++;
		end
		while (!bvalid && n < 50);
		chk("bvalid", 1, bvalid);
		r = bresp;
		bready <= 1'b0;
	endtask : axi_wr
	task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge clk);
		araddr <= a;
		arv <= 1'b1;
		rready <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			if (arrdy)
				arv <= 1'b0;
			n++;
		end
		while (!rvalid && n < 50);
		chk("rvalid", 1, rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : axi_rd
	task automatic clr();
		#1;
		stk_seen = 0;
		vec_cnt = 0;
		got_vec = 16'h0000;
	endtask : clr
	task automatic wait_vec(input logic [15:0] v, input int s_exp);
		for (int n = 0; n < 400 && vec_cnt == 0; n++)
			@(posedge clk);
		#1;
		chk("vector", v, got_vec);
		chk("stacked bytes", s_exp, stk_seen);
		chk("fetches", 1, vec_cnt);
	endtask : wait_vec
	task automatic service(input logic [31:0] c, input logic [15:0] v);
		logic [1:0] r;
		repeat (16) @(posedge clk);
		clr();
		axi_wr({28'h000_0000, ADDR_CTRL}, c, r);
		wait_vec(v, 7);
	endtask : service
	task automatic t_reset(input logic [2:0] m);
		logic [31:0] d;
		logic [1:0] r;
		clr();
		src.pin_reset(m);
		wait_vec(VEC_RESTART, 0);
		chk("upper", 8'hFF, upper);
		repeat (12) @(posedge clk);
		axi_rd({28'h000_0000, ADDR_PORT2}, d, r);
		chk("mode bits", m, d[7:5]);
		axi_rd({28'h000_0000, ADDR_CTRL}, d, r);
		chk("mask", 1, d[CTRL_SET_MASK]);
		$display("reset test done");
	endtask : t_reset
	task automatic t_mask();
		logic [31:0] d;
		logic [1:0] r;
		src.drive(1'b1, 1'b0, 6'h20);
		clr();
		axi_wr({28'h000_0000, ADDR_CTRL}, 32'h0000_0004, r);
		repeat (60) @(posedge clk);
		chk("masked stacking", 0, stk_seen);
		service(32'h0000_0005, VEC_EXT);
		axi_rd({28'h000_0000, ADDR_CTRL}, d, r);
		chk("mask", 1, d[CTRL_SET_MASK]);
		src.drive(1'b1, 1'b1, 6'h20);
		service(32'h0000_0005, VEC_CAPTURE);
		$display("mask test done");
	endtask : t_mask
	task automatic t_periph();
		logic [15:0] v [6] = '{VEC_CAPTURE, VEC_COMPARE, VEC_OVERFLOW, VEC_SERIAL, VEC_SERIAL, VEC_SERIAL};
		for (int i = 0; i < 6; i++)
		begin
			src.drive(1'b1, 1'b1, 6'h20 >> i);
			service(32'h0000_0005, v[i]);
		end
		src.drive(1'b1, 1'b1, 6'h00);
		$display("internal test done");
	endtask : t_periph
	task automatic t_other();
		logic [31:0] d;
		logic [1:0] r;
		src.drive(1'b0, 1'b1, 6'h00);
		service(32'h0000_0004, VEC_NONMASK);
		src.drive(1'b1, 1'b0, 6'h00);
		service(32'h0000_000D, VEC_TRAP);
		service(32'h0000_0005, VEC_EXT);
		src.drive(1'b1, 1'b1, 6'h00);
		axi_rd(32'h0000_0010, d, r);
		chk("unmapped read", RESP_SLVERR, r);
		axi_wr(32'h0000_0010, 32'h0000_0000, r);
		chk("unmapped write", RESP_SLVERR, r);
		$display("nmi trap bus test done");
	endtask : t_other
	task automatic complete_run();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : complete_run
	initial
	begin
		srst = 1'b1;
		{awv, wv, bready, arv, rready} = 5'h00;
		{awaddr, wdata, araddr} = '0;
		error_cnt = 0;
		num_checks = 0;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		t_reset(3'h5);
		t_mask();
		t_periph();
		t_other();
		t_reset(3'h2);
		complete_run();
	end
	initial
	begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		complete_run();
	end
endmodule : test_reset_interrupt_sequencer
